// ### hw/dmiu_pkg.sv
// Purpose: Constants, encodings and field helpers for the data move instruction unit
// Assumes: 16-bit program words, 12-bit data space, four phases per instruction cycle
// Notes:   Every opcode and instruction field position used by the core lives here, with the data, bank and address reset values
//
// What this block does
// - File move: 1100 source word, 1111 destination word
// - File move reaches all of 000h..FFFh, unbanked
// - File move copies byte; source, flags untouched
// - Accumulator may be file move source or destination
// - File move: two words, two cycles, one more per idle cycle
// - Decode 0000 0001 0000 kkkk as bank-select load
// - Bank-select load writes in fourth phase, no flags
// - Decode 0000 1110 kkkkkkkk as literal-to-accumulator load
// - Access bit zero: access bank; one: bank select
package dmiu_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;

  // ************************************************************
  // Opcode prefixes
  // ************************************************************
  localparam logic [3:0]  OPC_MOVE_SRC  = 4'hc;
  localparam logic [3:0]  OPC_MOVE_DST  = 4'hf;
  localparam logic [11:0] OPC_BANK_LOAD = 12'h010;
  localparam logic [7:0]  OPC_LIT_ACC   = 8'h0e;
  localparam logic [6:0]  OPC_ACC_STORE = 7'h37;

  // ************************************************************
  // Access bank split and reset values
  // ************************************************************
  localparam logic [7:0]        ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW   = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH  = 4'hf;
  localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET   = 12'h000;

  // ************************************************************
  // Phases of one instruction cycle
  // ************************************************************
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  typedef enum logic [1:0] {
    ST_DECODE = 2'b01,
    ST_DEST   = 2'b10
  } dmiu_state_e;

  // ************************************************************
  // Field extraction
  // ************************************************************
  function automatic logic [3:0] dmiuOp4(input logic [WORD_W-1:0] w);
    return w[15:12];
  endfunction : dmiuOp4

  function automatic logic [6:0] dmiuOp7(input logic [WORD_W-1:0] w);
    return w[15:9];
  endfunction : dmiuOp7

  function automatic logic [7:0] dmiuOp8(input logic [WORD_W-1:0] w);
    return w[15:8];
  endfunction : dmiuOp8

  function automatic logic [11:0] dmiuOp12(input logic [WORD_W-1:0] w);
    return w[15:4];
  endfunction : dmiuOp12

  function automatic logic [ADDR_W-1:0] dmiuAddr(input logic [WORD_W-1:0] w);
    return w[11:0];
  endfunction : dmiuAddr

  function automatic logic [DATA_W-1:0] dmiuLit8(input logic [WORD_W-1:0] w);
    return w[7:0];
  endfunction : dmiuLit8

  function automatic logic [BANK_W-1:0] dmiuLit4(input logic [WORD_W-1:0] w);
    return w[3:0];
  endfunction : dmiuLit4

  function automatic logic dmiuAccess(input logic [WORD_W-1:0] w);
    return w[8];
  endfunction : dmiuAccess

endpackage : dmiu_pkg

// ### hw/dmiu_core.sv
// Purpose: Decode and execute of four data movement instructions
// Assumes: One word offered per instruction cycle, sampled at the end of phase Q1
// Notes:   Data memory answers memRdata combinationally while memRead is high
`timescale 1ns/10ps
module dmiu_core #(
  parameter logic [dmiu_pkg::ADDR_W-1:0] ACC_ADDR = 12'hff8  // Arbitrary map slot
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          instrValid,
  input  wire logic [dmiu_pkg::WORD_W-1:0]   instrWord,
  input  wire logic [dmiu_pkg::DATA_W-1:0]   memRdata,
  output logic      [1:0]                    qPhase,
  output logic      [dmiu_pkg::ADDR_W-1:0]   memAddr,
  output logic      [dmiu_pkg::DATA_W-1:0]   memWdata,
  output logic                               memRead,
  output logic                               memWrite,
  output logic      [dmiu_pkg::DATA_W-1:0]   accumulator,
  output logic      [dmiu_pkg::BANK_W-1:0]   bankSelect,
  output logic                               moveBusy
);
  import dmiu_pkg::*;

  // ************************************************************
  // Internal state
  // ************************************************************
  dmiu_state_e         state;
  logic [WORD_W-1:0]   instr;
  logic                instrLive;
  logic [ADDR_W-1:0]   srcAddr;
  logic [ADDR_W-1:0]   dstAddr;
  logic [DATA_W-1:0]   moveData;
  logic                fromMove;
  logic                takeWord;
  logic                startMove;
  logic                takeDest;
  logic                isBank;
  logic                isLit;
  logic                isStore;
  logic [ADDR_W-1:0]   storeAddr;

  // Word acceptance happens only at the end of Q1
  assign takeWord  = (qPhase == PH_Q1) && instrValid;
  assign startMove = takeWord && (state == ST_DECODE)
                     && (dmiuOp4(instrWord) == OPC_MOVE_SRC);
  assign takeDest  = takeWord && (state == ST_DEST)
                     && (dmiuOp4(instrWord) == OPC_MOVE_DST);

  // Decode of the latched single-word instruction
  assign isBank  = instrLive && (dmiuOp12(instr) == OPC_BANK_LOAD);
  assign isLit   = instrLive && (dmiuOp8(instr) == OPC_LIT_ACC);
  assign isStore = instrLive && (dmiuOp7(instr) == OPC_ACC_STORE);

  // Banked address: access bank splits low and high halves
  always_comb
  begin
    if (dmiuAccess(instr))
    begin
      storeAddr = {bankSelect, dmiuLit8(instr)};
    end
    else if (dmiuLit8(instr) < ACCESS_SPLIT)
    begin
      storeAddr = {ACCESS_LOW, dmiuLit8(instr)};
    end
    else
    begin
      storeAddr = {ACCESS_HIGH, dmiuLit8(instr)};
    end
  end

  // ************************************************************
  // Phase divider
  // ************************************************************
  // Free running, so one instruction cycle is always four clocks
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      qPhase <= PH_Q1;
    else
      qPhase <= qPhase + PH_STEP;
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // A missing second word stretches the move by whole cycles; a wrong
  // prefix abandons it so a corrupt stream cannot write anywhere
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state     <= ST_DECODE;
      instr     <= '0;
      instrLive <= 1'b0;
      srcAddr   <= ADDR_RESET;
      dstAddr   <= ADDR_RESET;
      moveBusy  <= 1'b0;
    end
    else if (qPhase == PH_Q1)
    begin
      instrLive <= 1'b0;
      if (state == ST_DECODE)
      begin
        if (startMove)
        begin
          srcAddr  <= dmiuAddr(instrWord);
          state    <= ST_DEST;
          moveBusy <= 1'b1;
        end
        else if (takeWord)
        begin
          instr     <= instrWord;
          instrLive <= 1'b1;
        end
      end
      else if (takeWord)
      begin
        // Extended case: stays here while no word is offered
        state    <= ST_DECODE;
        moveBusy <= 1'b0;
        if (takeDest)
          dstAddr <= dmiuAddr(instrWord);
      end
    end
  end

  // ************************************************************
  // Memory strobes
  // ************************************************************
  // Strobes are set one clock ahead so they stand exactly in their phase
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      memRead  <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= ADDR_RESET;
      memWdata <= ACC_RESET;
      fromMove <= 1'b0;
    end
    else
    begin
      memRead  <= 1'b0;
      memWrite <= 1'b0;
      if (startMove && (dmiuAddr(instrWord) != ACC_ADDR))
      begin
        memAddr <= dmiuAddr(instrWord);
        memRead <= 1'b1;
      end
      else if ((qPhase == PH_Q3) && (state == ST_DECODE) && fromMove
               && (dstAddr != ACC_ADDR))
      begin
        memAddr  <= dstAddr;
        memWdata <= moveData;
        memWrite <= 1'b1;
      end
      else if ((qPhase == PH_Q3) && isStore)
      begin
        memAddr  <= storeAddr;
        memWdata <= accumulator;
        memWrite <= 1'b1;
      end
      // Marks a cycle whose Q4 belongs to the second word of a move
      if (qPhase == PH_Q1)
        fromMove <= takeDest;
    end
  end

  // ************************************************************
  // Source capture
  // ************************************************************
  // Accumulator source is taken from the register, not the bus
  // Only the first cycle's read is kept: a stretched move must not pick up an idle bus
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      moveData <= ACC_RESET;
    else if ((qPhase == PH_Q2) && (state == ST_DEST) && moveBusy
             && (memRead || (srcAddr == ACC_ADDR)))
      moveData <= (srcAddr == ACC_ADDR) ? accumulator : memRdata;
  end

  // ************************************************************
  // Accumulator and bank select
  // ************************************************************
  // No status flags exist here, so none can change
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      accumulator <= ACC_RESET;
      bankSelect  <= BANK_RESET;
    end
    else if (qPhase == PH_Q4)
    begin
      if (isLit)
        accumulator <= dmiuLit8(instr);
      else if (fromMove && (dstAddr == ACC_ADDR))
        accumulator <= moveData;
      if (isBank)
        bankSelect <= dmiuLit4(instr);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking dmiuClk @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence seqMoveStart;
    (qPhase == PH_Q1) && startMove;
  endsequence

  sequence seqMoveEnd;
    (qPhase == PH_Q1) && takeDest && (dmiuAddr(instrWord) != ACC_ADDR);
  endsequence

  a_read_phase: assert property (memRead |-> qPhase == PH_Q2)
    else $error("read strobe outside phase two");

  a_write_phase: assert property (memWrite |-> qPhase == PH_Q4)
    else $error("write strobe outside phase four");

  a_no_dummy_read: assert property ((fromMove || ((state == ST_DEST) && (qPhase != PH_Q2)))
    |-> !memRead)
    else $error("read during second move cycle");

  a_move_second: assert property (seqMoveStart |=> ##3 (state == ST_DEST))
    else $error("move did not wait for its second word");

  a_move_write: assert property (seqMoveEnd |-> ##3 (memWrite && memWdata == moveData))
    else $error("move destination not written in Q4");

  a_move_dest: assert property (seqMoveEnd |-> ##3 memAddr == $past(dmiuAddr(instrWord), 3))
    else $error("move wrote wrong address");

  a_bank_load: assert property ((qPhase == PH_Q4) && isBank
    |=> bankSelect == $past(dmiuLit4(instr)))
    else $error("bank select not loaded");

  a_lit_load: assert property ((qPhase == PH_Q4) && isLit
    |=> accumulator == $past(dmiuLit8(instr)))
    else $error("accumulator literal not loaded");

  a_store_data: assert property (memWrite && !fromMove
    |-> memWdata == accumulator)
    else $error("store wrote wrong data");

  a_access_bank: assert property (memWrite && !fromMove && !dmiuAccess(instr)
    |-> (memAddr[11:8] == ACCESS_LOW) || (memAddr[11:8] == ACCESS_HIGH))
    else $error("access bank address outside access bank");

endmodule : dmiu_core

// ### verif/dmiu_tb.sv
// Purpose: Self-checking bench for the data move instruction unit
// Assumes: Bench plays program and data memory; one word offered per cycle
// Notes:   Expectations come from bench functions, never from design outputs
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench;
  import dmiu_pkg::*;
  localparam logic [ADDR_W-1:0] ACC_MAP = 12'hff8;
  logic              core_clk   = 1'b0;
  logic              reset      = 1'b1;
  logic              instrValid = 1'b0;
  logic [WORD_W-1:0] instrWord  = 16'h0000;
  logic [DATA_W-1:0] memRdata;
  logic [1:0]        qPhase;
  logic [ADDR_W-1:0] memAddr;
  logic [DATA_W-1:0] memWdata;
  logic              memRead;
  logic              memWrite;
  logic [DATA_W-1:0] accumulator;
  logic [BANK_W-1:0] bankSelect;
  logic              moveBusy;
  logic [DATA_W-1:0] mem [4096];
  logic [DATA_W-1:0] expMem [4096];
  logic [DATA_W-1:0] expAcc   = 8'h00;
  logic [BANK_W-1:0] expBank  = 4'h0;
  logic [BANK_W-1:0] lastBank = 4'h0;
  int                n_fail    = 0;
  int                cmp_count = 0;
  int                cycles    = 0;

  // ************************************************************
  // Clock, design and data memory
  // ************************************************************
  always #10 core_clk = ~core_clk;

  dmiu_core #(.ACC_ADDR(ACC_MAP)) i_dut (
    .core_clk    (core_clk),
    .reset       (reset),
    .instrValid  (instrValid),
    .instrWord   (instrWord),
    .memRdata    (memRdata),
    .qPhase      (qPhase),
    .memAddr     (memAddr),
    .memWdata    (memWdata),
    .memRead     (memRead),
    .memWrite    (memWrite),
    .accumulator (accumulator),
    .bankSelect  (bankSelect),
    .moveBusy    (moveBusy)
  );

  // Unread bus shows a moving pattern so a stale sample cannot pass by luck
  assign memRdata = (memRead === 1'b1) ? mem[memAddr] : cycles[7:0];

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Memory writes, phase placement of bus strobes, and the hang limit
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (memWrite === 1'b1)
      mem[memAddr] <= memWdata;
    if (memRead === 1'b1)
      `CHK("readPhase", PH_Q2, qPhase)
    if (memWrite === 1'b1)
      `CHK("writePhase", PH_Q4, qPhase)
    // Written on the edge ending Q4, so the new value is first seen in Q1
    if (!reset && (bankSelect !== lastBank))
      `CHK("bankPhase", PH_Q1, qPhase)
    lastBank <= bankSelect;
    if (cycles == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // ************************************************************
  // Drivers and expectations
  // ************************************************************
  // Word is driven at the edge entering Q1 and taken at the next edge
  task automatic issue(input logic [WORD_W-1:0] w);
    do @(negedge core_clk); while (qPhase !== PH_Q4);
    @(posedge core_clk);
    instrWord  <= w;
    instrValid <= 1'b1;
    @(posedge core_clk);
    instrValid <= 1'b0;
  endtask : issue

  task automatic settle();
    repeat (5) @(negedge core_clk);
  endtask : settle

  function automatic logic [ADDR_W-1:0] bankAddr(input logic a, input logic [7:0] f,
                                                 input logic [BANK_W-1:0] b);
    if (a)
      return {b, f};
    return {((f < 8'h80) ? 4'h0 : 4'hf), f};
  endfunction : bankAddr

  task automatic store(input logic a, input logic [7:0] f);
    logic [ADDR_W-1:0] ad;
    ad = bankAddr(a, f, expBank);
    issue({7'h37, a, f});
    settle();
    expMem[ad] = expAcc;
    `CHK("storeMem", expAcc, mem[ad])
  endtask : store

  // Gap in whole instruction cycles stretches the move into its extended form
  task automatic move(input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] d, input int gap);
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] srcNow;
    v = (s == ACC_MAP) ? expAcc : expMem[s];
    issue({4'hc, s});
    repeat (gap * 4) @(negedge core_clk);
    if (gap > 0)
      `CHK("busyGap", 1'b1, moveBusy)
    issue({4'hf, d});
    settle();
    if (d == ACC_MAP)
      expAcc = v;
    else
      expMem[d] = v;
    `CHK("moveDst", v, (d == ACC_MAP) ? accumulator : mem[d])
    srcNow = (s == ACC_MAP) ? accumulator : mem[s];
    `CHK("moveSrc", (s == ACC_MAP) ? expAcc : expMem[s], srcNow)
  endtask : move

  logic [ADDR_W-1:0] rs;
  logic [ADDR_W-1:0] rd;
  logic [7:0]        k;

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(33697));
    for (int i = 0; i < 4096; i++)
    begin
      mem[i] = 8'($urandom);
      expMem[i] = mem[i];
    end
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // Every bank value, each through its own load
    for (int b = 0; b < 16; b++)
    begin
      expBank = 4'(b);
      issue({12'h010, expBank});
      settle();
      `CHK("bank", expBank, bankSelect)
    end
    for (int i = 0; i < 8; i++)
    begin
      k = 8'($urandom);
      expAcc = (i == 0) ? 8'hff : k;
      issue({8'h0e, expAcc});
      settle();
      `CHK("acc", expAcc, accumulator)
    end
    // Access bank split corners, then random stores with random bank and access bit
    store(1'b0, 8'h7f);
    store(1'b0, 8'h80);
    store(1'b1, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      expBank = 4'($urandom);
      issue({12'h010, expBank});
      k = 8'($urandom);
      expAcc = k;
      issue({8'h0e, k});
      store(1'($urandom), 8'($urandom) & 8'hf7);
    end
    move(12'h000, 12'hfff, 0);
    move(12'hfff, 12'h000, 1);
    move(ACC_MAP, 12'h123, 0);
    move(12'h456, ACC_MAP, 2);
    `CHK("accDst", expMem[12'h456], accumulator)
    // Plain data bytes only: no control byte as target, no interrupt setup
    for (int i = 0; i < 10; i++)
    begin
      rs = 12'($urandom);
      rd = 12'($urandom);
      move((rs == ACC_MAP) ? 12'h001 : rs, (rd == ACC_MAP) ? 12'h002 : rd, i % 3);
    end
    // Wrong second word abandons the move and is itself discarded
    issue({4'hc, 12'h234});
    issue({8'h0e, 8'h5a});
    settle();
    `CHK("abortAcc", expAcc, accumulator)
    // Literal load straight into a move that reads the accumulator
    expAcc = 8'ha5;
    issue({8'h0e, expAcc});
    move(ACC_MAP, 12'h321, 0);
    stop_test();
  end
endmodule : testbench
